// file: design/ptw_timer.sv
// Periodic tick counter and watchdog with a shared prescaler
// What this block does
// - Prescaler, watchdog and tick counters count up and are zero after reset.
// - The prescaler runs at a fixed division, feeds both counters and only the global reset clears it.
// - The prescaler divides the 32,768 Hz input by 64 for a tick of about 1.953 ms.
// - With the watchdog reset enabled, a fall of the selected watchdog tap issues a system reset.
// - Watchdog enable and period select accept only the first write after each system reset.
// - Writing 1 to control bit 3 clears the watchdog counter.
// - A fall of the selected tick tap raises the tick interrupt when the tick interrupt enable is set.
// - Writing 1 to control bit 7 clears the tick counter.
// - No counter value can be read by software.
// - While halt is high the slow clock to the prescaler is gated so nothing advances.
// - Tick select 00/01/10/11 gives periods of 4,096/8,192/16,384/32,768 slow cycles.
// - Watchdog select 00/01/10/11 gives timeouts of 16,384/32,768/65,536/131,072 slow cycles.
// - Control bit 2 enables the watchdog reset and is zero after reset.
//
// Implementation choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
module ptw_timer
   import ptw_pkg::*;
#(
   parameter int SYSRST_CYCLES = PTW_SYSRST_CYCLES
)(
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        reset_n,
   // Slow time base and halt, both from outside the clock domain
   input  wire logic        slow_clk,
   input  wire logic        halt,
   // Wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [13:0] wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // Events
   output logic             irq,
   output logic             tick_irq,
   output logic             sys_reset_req
);
   logic                         slow_s;
   logic                         slow_q;
   logic                         halt_s;
   logic                         slow_edge;
   logic [PTW_PRESCALE_BITS-1:0] prescale;
   logic                         pre_tick;
   logic [PTW_TICK_BITS-1:0]     tick_count;
   logic [PTW_WDOG_BITS-1:0]     wdog_count;
   logic                         wr_any;
   logic                         tick_fall;
   logic                         wdog_fall;
   ptw_ctrl_type                 ctrl;
   logic                         ctrl_locked;
   logic                         tick_irq_enable;
   logic                         halt_reg;
   logic [1:0]                   irq_status;
   logic [1:0]                   irq_mask;
   logic [1:0]                   next_irq_status;
   logic [PTW_PULSE_BITS-1:0]    rst_pulse;
   logic                         wb_req;
   logic                         wr_ctrl;
   logic                         rd_status;
   logic                         lane0;

   // Both pins pass two flops before any logic reads them
   ptw_sync #(
      .RESET_VALUE (1'b0)
   ) slow_sync_i (
      .sys_clk  (sys_clk),
      .reset_n  (reset_n),
      .pin      (slow_clk),
      .pin_sync (slow_s)
   );

   ptw_sync #(
      .RESET_VALUE (1'b0)
   ) halt_sync_i (
      .sys_clk  (sys_clk),
      .reset_n  (reset_n),
      .pin      (halt),
      .pin_sync (halt_s)
   );

   // Third flop only for the rising-edge test
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
         slow_q <= 1'b0;
      else
         slow_q <= slow_s;
   end

   // Halt pin or software halt bit gates the slow clock
   assign slow_edge = slow_s & ~slow_q & ~halt_s & ~halt_reg;

   // Free prescaler, no software clear
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
         prescale <= '0;
      else if (slow_edge)
         prescale <= prescale + 1'b1;
   end

   assign pre_tick = slow_edge & (&prescale);

   // Tick counter with clear
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
         tick_count <= '0;
      else if (wr_ctrl && wb_dat_i[PTW_BIT_TICK_CLEAR])
         tick_count <= '0;
      else if (pre_tick)
         tick_count <= tick_count + 1'b1;
   end

   // Watchdog counter with clear
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
         wdog_count <= '0;
      else if (wr_ctrl && wb_dat_i[PTW_BIT_WDOG_CLEAR])
         wdog_count <= '0;
      else if (pre_tick)
         wdog_count <= wdog_count + 1'b1;
   end

   // 4,096 slow cycles is prescaler 64 times tick bit 5
   ptw_tap_fall #(
      .COUNT_BITS (PTW_TICK_BITS),
      .TAP0       (PTW_TICK_TAP0)
   ) tick_tap_i (
      .sys_clk (sys_clk),
      .reset_n (reset_n),
      .count   (tick_count),
      .select  (ctrl.tick_period_select),
      .fall    (tick_fall)
   );

   ptw_tap_fall #(
      .COUNT_BITS (PTW_WDOG_BITS),
      .TAP0       (PTW_WDOG_TAP0)
   ) wdog_tap_i (
      .sys_clk (sys_clk),
      .reset_n (reset_n),
      .count   (wdog_count),
      .select  (ctrl.wdog_period_select),
      .fall    (wdog_fall)
   );

   // Bus decode
   assign wb_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign lane0   = wb_sel_i[0];
   assign wr_ctrl = wb_req & wb_we_i & lane0 & (wb_adr_i == PTW_CTRL_ADDR);
   assign rd_status = wb_req & ~wb_we_i & (wb_adr_i == PTW_IRQ_STATUS_ADDR);
   assign wr_any    = wb_req & wb_we_i & lane0;

   // Control register; watchdog fields lock after the first write
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ctrl        <= '0;
         ctrl_locked <= 1'b0;
      end
      else if (wr_ctrl)
      begin
         ctrl.tick_period_select <= wb_dat_i[PTW_BIT_TSEL_HI:PTW_BIT_TSEL_LO];
         if (!ctrl_locked)
         begin
            ctrl.wdog_reset_enable  <= wb_dat_i[PTW_BIT_WDOG_EN];
            ctrl.wdog_period_select <= wb_dat_i[PTW_BIT_WSEL_HI:PTW_BIT_WSEL_LO];
            ctrl_locked             <= 1'b1;
         end
      end
   end

   // Tick interrupt enable, stand-in for the outer enable register
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
         tick_irq_enable <= 1'b0;
      else if (wr_any && (wb_adr_i == PTW_TICK_IE_ADDR))
         tick_irq_enable <= wb_dat_i[0];
   end

   // Interrupt mask, same layout as status
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
         irq_mask <= 2'h0;
      else if (wr_any && (wb_adr_i == PTW_IRQ_MASK_ADDR))
         irq_mask <= wb_dat_i[1:0];
   end

   // Software halt, ORed with the pin
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
         halt_reg <= 1'b0;
      else if (wr_any && (wb_adr_i == PTW_HALT_ADDR))
         halt_reg <= wb_dat_i[0];
   end

   // Sticky status, cleared by read; a new event wins over the clear
   always_comb
   begin
      next_irq_status = rd_status ? 2'h0 : irq_status;
      if (tick_fall && tick_irq_enable)
         next_irq_status[PTW_EV_TICK] = 1'b1;
      if (wdog_fall && ctrl.wdog_reset_enable)
         next_irq_status[PTW_EV_WDOG] = 1'b1;
   end

   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         irq_status <= 2'h0;
         irq        <= 1'b0;
      end
      else
      begin
         irq_status <= next_irq_status;
         irq        <= |(next_irq_status & irq_mask);
      end
   end

   // Tick pulse, one cycle per tap fall while the tick interrupt enable is set
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
         tick_irq <= 1'b0;
      else
         tick_irq <= tick_fall & tick_irq_enable;
   end

   // System reset pulse; the host reset network returns reset_n to us
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rst_pulse     <= '0;
         sys_reset_req <= 1'b0;
      end
      else
      begin
         if (wdog_fall && ctrl.wdog_reset_enable)
            rst_pulse <= PTW_PULSE_BITS'(SYSRST_CYCLES);
         else if (rst_pulse != '0)
            rst_pulse <= rst_pulse - 1'b1;
         sys_reset_req <= (wdog_fall && ctrl.wdog_reset_enable) || (rst_pulse > 1);
      end
   end

   // Read path, one-cycle ack; counters not visible
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end
      else
      begin
         wb_ack_o <= wb_req;
         wb_dat_o <= 32'h0;
         if (wb_req && !wb_we_i)
         begin
            case (wb_adr_i)
               PTW_CTRL_ADDR:
                  wb_dat_o <= 32'({2'b00, ctrl.tick_period_select, 1'b0, ctrl.wdog_reset_enable,
                                   ctrl.wdog_period_select});
               PTW_IRQ_STATUS_ADDR: wb_dat_o <= 32'(irq_status);
               PTW_IRQ_MASK_ADDR:   wb_dat_o <= 32'(irq_mask);
               PTW_TICK_IE_ADDR:    wb_dat_o <= 32'(tick_irq_enable);
               PTW_HALT_ADDR:       wb_dat_o <= 32'(halt_reg);
               default:             wb_dat_o <= 32'h0;
            endcase
         end
      end
   end
endmodule

// Tap selection and fall detection, one per counter
module ptw_tap_fall
   import ptw_pkg::*;
#(
   parameter int COUNT_BITS = PTW_TICK_BITS,
   parameter int TAP0       = PTW_TICK_TAP0
)(
   // Clock and reset
   input  wire logic                  sys_clk,
   input  wire logic                  reset_n,
   // Counter and tap choice
   input  wire logic [COUNT_BITS-1:0] count,
   input  wire logic [1:0]            select,
   // Result
   output logic                       fall
);
   logic tap;
   logic tap_q;

   // Each select step doubles the period by moving one bit up
   assign tap = count[TAP0 + 32'(select)];

   // History follows the selection, so a select change alone may fire
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
         tap_q <= 1'b0;
      else
         tap_q <= tap;
   end

   assign fall = tap_q & ~tap;
endmodule

// Two-flop synchroniser for one asynchronous pin
module ptw_sync
#(
   parameter logic RESET_VALUE = 1'b0
)(
   // Clock and reset
   input  wire logic sys_clk,
   input  wire logic reset_n,
   // Pin and its synchronised copy
   input  wire logic pin,
   output logic      pin_sync
);
   logic meta;

   // Nothing but the second flop reads the first
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         meta     <= RESET_VALUE;
         pin_sync <= RESET_VALUE;
      end
      else
      begin
         meta     <= pin;
         pin_sync <= meta;
      end
   end
endmodule

// file: design/ptw_pkg.sv
// Package for the periodic tick and watchdog timer
package ptw_pkg;
   // Bus map: register index 0x0D8 as printed, byte address four times it
   localparam logic [11:0] PTW_CTRL_INDEX  = 12'h0D8;
   localparam logic [13:0] PTW_CTRL_ADDR   = {PTW_CTRL_INDEX, 2'b00};
   localparam logic [13:0] PTW_IRQ_STATUS_ADDR = 14'h0400;
   localparam logic [13:0] PTW_IRQ_MASK_ADDR   = 14'h0404;
   localparam logic [13:0] PTW_TICK_IE_ADDR    = 14'h0408;
   localparam logic [13:0] PTW_HALT_ADDR       = 14'h040C;
   // Control field positions
   localparam int PTW_BIT_TICK_CLEAR = 7;
   localparam int PTW_BIT_TSEL_HI    = 5;
   localparam int PTW_BIT_TSEL_LO    = 4;
   localparam int PTW_BIT_WDOG_CLEAR = 3;
   localparam int PTW_BIT_WDOG_EN    = 2;
   localparam int PTW_BIT_WSEL_HI    = 1;
   localparam int PTW_BIT_WSEL_LO    = 0;
   localparam logic [7:0] PTW_CTRL_RESET = 8'h00;
   // Interrupt status bits
   localparam int PTW_EV_TICK = 0;
   localparam int PTW_EV_WDOG = 1;
   localparam int PTW_EV_W    = 2;
   // Timing
   localparam int PTW_PRESCALE_BITS = 6;
   localparam int PTW_TICK_BITS     = 9;
   localparam int PTW_WDOG_BITS     = 11;
   localparam int PTW_TICK_TAP0     = 5;
   localparam int PTW_WDOG_TAP0     = 7;
   localparam int PTW_SYS_CLK_MHZ   = 250;
   localparam int PTW_SLOW_CLK_HZ   = 32768;
   localparam int PTW_SYSRST_NS     = 1000;
   localparam int PTW_SYSRST_CYCLES = (PTW_SYSRST_NS * PTW_SYS_CLK_MHZ) / 1000;
   localparam int PTW_PULSE_BITS    = 8;

   typedef struct packed {
      logic [1:0] tick_period_select;
      logic       wdog_reset_enable;
      logic [1:0] wdog_period_select;
   } ptw_ctrl_type;
endpackage

// file: verif/ptw_timer_checker.sv
// Assertions on the timer bus and event outputs
`timescale 1ns/1ps
module ptw_timer_checker
   import ptw_pkg::*;
#(
   parameter int SYSRST_CYCLES = 4
)(
   // Clock and reset
   input wire logic        sys_clk,
   input wire logic        reset_n,
   // Time base and halt
   input wire logic        slow_clk,
   input wire logic        halt,
   // Bus
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [13:0] wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   // Events
   input wire logic        irq,
   input wire logic        tick_irq,
   input wire logic        sys_reset_req
);
   int rst_len;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   // Length of the reset pulse so far
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
         rst_len <= 0;
      else
         rst_len <= sys_reset_req ? rst_len + 1 : 0;
   end
   a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack missing after request");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
   a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
   a_read_clean: assert property (wb_ack_o && !$past(wb_we_i) |-> wb_dat_o[31:8] == 24'h000000)
      else $error("upper read bits not zero");
   a_ctrl_zeros: assert property (wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == PTW_CTRL_ADDR
      |-> (wb_dat_o & 32'hFFFFFFC8) == 32'h00000000) else $error("clear or unused bit reads one");
   a_tick_pulse: assert property (tick_irq |=> !tick_irq) else $error("tick pulse too long");
   a_rst_len: assert property ($fell(sys_reset_req) |-> rst_len == SYSRST_CYCLES)
      else $error("reset pulse length wrong");
   // Sixteen cycles leave room for an edge already in the synchroniser
   a_halt_freeze: assert property (halt [*8] ##1 halt [*8] |-> !tick_irq && !$rose(sys_reset_req))
      else $error("event while halted");
   a_reset_quiet: assert property ($rose(reset_n) |-> !(wb_ack_o || irq || tick_irq || sys_reset_req))
      else $error("output active after reset");
   c_tick: cover property (tick_irq);
   c_wdog: cover property ($rose(sys_reset_req));
   c_irq_read: cover property (wb_ack_o && irq);
endmodule
bind ptw_timer ptw_timer_checker #(.SYSRST_CYCLES(SYSRST_CYCLES)) chk (.sys_clk(sys_clk), .reset_n(reset_n),
   .slow_clk(slow_clk), .halt(halt), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .irq(irq), .tick_irq(tick_irq), .sys_reset_req(sys_reset_req));

// file: verif/ptw_timer_tb_top.sv
// Self-checking bench for the tick and watchdog timer
`timescale 1ns/1ps
module ptw_timer_tb_top;
   import ptw_pkg::*;
   logic        sys_clk = 1'h0, reset_n = 1'h0, slow_clk = 1'h0, halt = 1'h0, tgl = 1'h0;
   logic        wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0, rst_d;
   logic [13:0] wb_adr_i = 14'h0000;
   logic [3:0]  wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
   logic        wb_ack_o, irq, tick_irq, sys_reset_req;
   int          n_mismatch = 0, n_compared = 0, seed = 29, slow_cnt = 0, last;
   logic [31:0] rd_q[$];
   int          tq[$], wq[$];

   ptw_timer #(.SYSRST_CYCLES(4)) dut (.sys_clk(sys_clk), .reset_n(reset_n), .slow_clk(slow_clk), .halt(halt),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq(irq), .tick_irq(tick_irq),
      .sys_reset_req(sys_reset_req));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED at %0t seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   task automatic summarize();
      if (n_mismatch == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // One classic cycle; random upper lanes must not disturb the byte register
   task automatic bus(input logic we, input logic [13:0] a, input logic [7:0] d);
      wb_cyc_i <= 1'h1;
      wb_stb_i <= 1'h1;
      wb_we_i  <= we;
      wb_adr_i <= a;
      wb_sel_i <= {3'($random(seed)), 1'h1};
      wb_dat_i <= {24'($random(seed)), d};
      @(posedge sys_clk);
      while (wb_ack_o !== 1'h1)
         @(posedge sys_clk);
      last = slow_cnt;
      wb_cyc_i <= 1'h0;
      wb_stb_i <= 1'h0;
      @(posedge sys_clk);
   endtask

   task automatic rd(input logic [13:0] a, input logic [31:0] e);
      rd_q.push_back(e);
      bus(1'h0, a, 8'h00);
   endtask

   // Event accepted from one prescaler period before to 4 slow cycles after its nominal time
   function automatic logic [31:0] win(input int e);
      return 32'(slow_cnt >= e - 64 && slow_cnt <= e + 4);
   endfunction

   initial
   begin
      forever #2 sys_clk = ~sys_clk;
   end

   // Slow base at a quarter of sys_clk; slow_cnt skips halted cycles
   always @(posedge sys_clk)
   begin
      tgl <= ~tgl;
      if (tgl)
         slow_clk <= ~slow_clk;
      if (tgl && !slow_clk && !halt)
         slow_cnt <= slow_cnt + 1;
   end

   always @(posedge sys_clk)
   begin
      rst_d <= sys_reset_req;
      if (wb_ack_o === 1'h1 && !wb_we_i)
         check(wb_dat_o, rd_q.pop_front());
      if (tick_irq === 1'h1)
         check(win(tq.pop_front()), 32'h1);
      if (sys_reset_req === 1'h1 && rst_d === 1'h0)
         check(win(wq.pop_front()), 32'h1);
   end

   // About 82k cycles expected; the limit leaves some margin
   initial
   begin
      #390000;
      n_mismatch++;
      summarize();
   end

   initial
   begin
      repeat (20) @(posedge sys_clk);
      reset_n <= 1'h1;
      @(posedge sys_clk);
      rd(PTW_CTRL_ADDR, 32'h0);
      rd(14'h0123, 32'h0);
      bus(1'h1, PTW_CTRL_ADDR, 8'h8C);
      for (int k = 1; k <= 5; k++)
         tq.push_back(last + 4096 * k);
      rd(PTW_CTRL_ADDR, 32'h04);
      bus(1'h1, PTW_CTRL_ADDR, 8'h03);
      rd(PTW_CTRL_ADDR, 32'h04);
      bus(1'h1, PTW_IRQ_MASK_ADDR, 8'h01);
      bus(1'h1, PTW_TICK_IE_ADDR, 8'h01);
      wait (slow_cnt >= last + 3500);
      @(posedge sys_clk);
      bus(1'h1, PTW_CTRL_ADDR, 8'h08);
      wq.push_back(last + 16384);
      @(posedge tick_irq);
      repeat (3) @(negedge sys_clk);
      check(irq, 32'h1);
      @(posedge sys_clk);
      rd(PTW_IRQ_STATUS_ADDR, 32'h01);
      @(negedge sys_clk);
      check(irq, 32'h0);
      @(posedge sys_clk);
      bus(1'h1, PTW_IRQ_MASK_ADDR, 8'h00);
      halt <= 1'h1;
      repeat (2000) @(posedge sys_clk);
      halt <= 1'h0;
      @(posedge sys_reset_req);
      repeat (8) @(negedge sys_clk);
      check(irq, 32'h0);
      check(tq.size(), 32'h1);
      @(posedge sys_clk);
      rd(PTW_IRQ_STATUS_ADDR, 32'h03);
      reset_n <= 1'h0;
      repeat (20) @(posedge sys_clk);
      reset_n <= 1'h1;
      @(posedge sys_clk);
      rd(PTW_CTRL_ADDR, 32'h0);
      bus(1'h1, PTW_CTRL_ADDR, 8'hBB);
      rd(PTW_CTRL_ADDR, 32'h33);
      summarize();
   end
endmodule
